// >>> hw/prn_err_pkg.sv
// constants, types and encodings shared by the printer fault reporter
//
// Overview of operation
// - near-end shows paper-end 0, fault 1, both status bits 0
// - near-end routed to paper-end pin replaces the dedicated near-end pattern
// - head temperature above 70 degC raises the temperature fault
// - temperature fault clears itself once head cools below 60 degC
// - temperature fault shows paper-end 0, fault 0, low bit 1, high 0
// - fault lamp lights for temperature, cutter, voltage, hardware, mark faults
// - DTR high while any reportable fault persists; host waits 4 seconds
// - after each cut check blade home; not home raises cutter fault
// - cutter fault shows paper-end 0, fault 0, both status bits 1
// - cutter fault holds until init, which re-homes blade and rechecks
// - head supply outside 21,6V to 26,4V raises voltage fault
// - voltage fault shows paper-end 0, fault 0, low 0, high 1
// - voltage fault latches until power cycle with supply back in range
// - init self-check failure latches hardware fault with voltage pattern
// - mark checking only when strapped on at start; missing mark faults
// - optical mark fault drives all four status pins 0
// - optical mark fault latches until power off
// - no paper or open head: paper-end 1, fault 1, lamp, motor stop
// - near-end stop setting decides halt and DTR; otherwise poll only
package prn_err_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;

  // control register fields
  localparam int         SENSOR_PAPER_BIT = 0;
  localparam int         SENSOR_NEAR_BIT  = 1;
  localparam int         NEAR_STOP_BIT    = 2;
  localparam logic [2:0] CTRL_RESET       = 3'h1;

  // thresholds: degC and tenths of a volt
  localparam logic [7:0] TEMP_HOT_C  = 8'h46;
  localparam logic [7:0] TEMP_COOL_C = 8'h3C;
  localparam logic [8:0] VOLT_MIN_DV = 9'h0D8;
  localparam logic [8:0] VOLT_MAX_DV = 9'h108;

  // cycles after reset release before synchronised pins are trusted
  localparam logic [1:0] BOOT_WAIT = 2'h3;
  localparam logic [1:0] BOOT_CNT_RESET = 2'h0;

  typedef enum logic [2:0] {
    PH_BOOT   = 3'h1,
    PH_REHOME = 3'h2,
    PH_RUN    = 3'h4
  } phase_t;

  typedef struct packed {
    logic pe;
    logic fault_n;
    logic st_hi;
    logic st_lo;
  } port_pins_t;

  // parallel status patterns {pe, fault_n, st_hi, st_lo}
  localparam port_pins_t PAT_PAPER_END = 4'hC;
  localparam port_pins_t PAT_IDLE      = 4'h4;
  localparam port_pins_t PAT_TEMP      = 4'h1;
  localparam port_pins_t PAT_CUTTER    = 4'h3;
  localparam port_pins_t PAT_NONREC    = 4'h2;
  localparam port_pins_t PAT_MARK      = 4'h0;
  localparam port_pins_t PINS_RESET    = 4'h4;

  typedef struct packed {
    logic paper_end;
    logic near_end;
    logic temp;
    logic cutter;
    logic volt;
    logic hw;
    logic mark;
  } fault_t;

  localparam fault_t FAULT_RESET = 7'h00;

  // synchronised pin vector positions
  localparam int PIN_PAPER_OUT   = 0;
  localparam int PIN_HEAD_OPEN   = 1;
  localparam int PIN_NEAR_END    = 2;
  localparam int PIN_CUTTER_HOME = 3;
  localparam int PIN_MARK_STRAP  = 4;
  localparam int PIN_COUNT       = 5;

endpackage : prn_err_pkg

// >>> hw/pin_sync2.sv
// two flip-flop synchroniser for a group of asynchronous pins
`timescale 1ns/10ps
module pin_sync2 #(
  parameter int W = 1
) (
  input  wire logic         CLK,
  input  wire logic         RESETN,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_state_t;

  sync_state_t st_r;
  sync_state_t st_nxt;

  always_comb begin
    st_nxt        = st_r;
    st_nxt.meta   = async_in;
    st_nxt.stable = st_r.meta;
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.stable;

endmodule : pin_sync2

// >>> hw/printer_error_reporter.sv
// fault detection and parallel/serial status reporting of the receipt printer
//
// The AHB-Lite slave port and the address map were decided locally.
`timescale 1ns/10ps
module printer_error_reporter (
  input  wire logic        CLK,
  input  wire logic        RESETN,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic             HREADYOUT,
  output logic      [31:0] HRDATA,
  output logic             HRESP,
  input  wire logic        PAPER_OUT_IN,
  input  wire logic        HEAD_OPEN_IN,
  input  wire logic        NEAR_END_IN,
  input  wire logic        CUTTER_HOME_IN,
  input  wire logic        MARK_STRAP_IN,
  input  wire logic        CUT_DONE,
  input  wire logic        MARK_MISS,
  input  wire logic        REHOME_DONE,
  input  wire logic        HW_SELF_OK,
  input  wire logic        MEAS_VALID,
  input  wire logic [7:0]  HEAD_TEMP_C,
  input  wire logic [8:0]  HEAD_SUPPLY_VOLTAGE,
  output logic             PAPER_END_OUT,
  output logic             FAULT_OUT_N,
  output logic             STATUS_BIT_LOW,
  output logic             STATUS_BIT_HIGH,
  output logic             FAULT_LAMP,
  output logic             PAPER_LAMP,
  output logic             MOTOR_STOP,
  output logic             DTR,
  output logic             CUTTER_REHOME
);

  typedef struct packed {
    prn_err_pkg::phase_t     phase;
    logic [1:0]              boot_cnt;
    logic [2:0]              ctrl;
    logic                    mark_en;
    prn_err_pkg::fault_t     flt;
    prn_err_pkg::port_pins_t pins;
    logic                    lamp_err;
    logic                    lamp_pe;
    logic                    motor_stop;
    logic                    dtr;
    logic                    rehome;
    logic                    wr_pend;
    logic [7:0]              wr_addr;
    logic [31:0]             rdata;
  } state_t;

  state_t                              st_r;
  state_t                              st_nxt;
  logic [prn_err_pkg::PIN_COUNT-1:0]   pins_async;
  logic [prn_err_pkg::PIN_COUNT-1:0]   pins_s;
  logic                                ahb_go;
  logic [31:0]                         rd_word;
  logic                                pe_route;
  logic                                nonrec;
  logic                                err_any;
  logic                                near_halt;

  assign pins_async = {MARK_STRAP_IN, CUTTER_HOME_IN, NEAR_END_IN, HEAD_OPEN_IN, PAPER_OUT_IN};

  pin_sync2 #(
    .W (prn_err_pkg::PIN_COUNT)
  ) u_sync (
    .CLK      (CLK),
    .RESETN   (RESETN),
    .async_in (pins_async),
    .sync_out (pins_s)
  );

  // AHB-Lite: zero wait, always OKAY, whole-word registers
  assign ahb_go = HSEL && HTRANS[1] && HREADY;

  always_comb begin
    rd_word = 32'h0000_0000;
    if (HADDR[31:8] == 24'h00_0000) begin
      case (HADDR[7:0])
        prn_err_pkg::CTRL_OFS: begin
          rd_word = {29'h0000_0000, st_r.ctrl};
        end
        prn_err_pkg::STATUS_OFS: begin
          rd_word = {16'h0000, st_r.phase, st_r.mark_en, st_r.dtr, st_r.pins, st_r.flt};
        end
        default: begin
          rd_word = 32'h0000_0000;
        end
      endcase
    end
  end

  // fault classes derived from the registered flags
  assign pe_route  = (st_r.ctrl[prn_err_pkg::SENSOR_PAPER_BIT] && st_r.flt.paper_end)
                   || (st_r.ctrl[prn_err_pkg::SENSOR_NEAR_BIT] && st_r.flt.near_end);
  assign nonrec    = st_r.flt.volt || st_r.flt.hw;
  assign err_any   = st_r.flt.temp || st_r.flt.cutter || nonrec || st_r.flt.mark;
  assign near_halt = st_r.flt.near_end && st_r.ctrl[prn_err_pkg::NEAR_STOP_BIT];

  always_comb begin
    st_nxt        = st_r;
    st_nxt.rehome = 1'b0;

    // register bus
    st_nxt.wr_pend = 1'b0;
    if (st_r.wr_pend && st_r.wr_addr == prn_err_pkg::CTRL_OFS) begin
      st_nxt.ctrl = HWDATA[2:0];
    end
    if (ahb_go) begin
      st_nxt.wr_pend = HWRITE && (HADDR[31:8] == 24'h00_0000);
      st_nxt.wr_addr = HADDR[7:0];
      if (!HWRITE) begin
        st_nxt.rdata = rd_word;
      end
    end

    st_nxt.flt.paper_end = pins_s[prn_err_pkg::PIN_PAPER_OUT] || pins_s[prn_err_pkg::PIN_HEAD_OPEN];
    st_nxt.flt.near_end  = pins_s[prn_err_pkg::PIN_NEAR_END];

    if (MEAS_VALID) begin
      if (HEAD_TEMP_C > prn_err_pkg::TEMP_HOT_C) begin
        st_nxt.flt.temp = 1'b1;
      end else if (HEAD_TEMP_C < prn_err_pkg::TEMP_COOL_C) begin
        st_nxt.flt.temp = 1'b0;
      end
      if (HEAD_SUPPLY_VOLTAGE < prn_err_pkg::VOLT_MIN_DV || HEAD_SUPPLY_VOLTAGE > prn_err_pkg::VOLT_MAX_DV) begin
        st_nxt.flt.volt = 1'b1;
      end
    end

    case (st_r.phase)
      prn_err_pkg::PH_BOOT: begin
        if (st_r.boot_cnt == prn_err_pkg::BOOT_WAIT) begin
          st_nxt.mark_en = pins_s[prn_err_pkg::PIN_MARK_STRAP];
          st_nxt.rehome  = 1'b1;
          st_nxt.phase   = prn_err_pkg::PH_REHOME;
        end else begin
          st_nxt.boot_cnt = st_r.boot_cnt + 2'h1;
        end
      end
      prn_err_pkg::PH_REHOME: begin
        if (REHOME_DONE) begin
          if (!pins_s[prn_err_pkg::PIN_CUTTER_HOME]) begin
            st_nxt.flt.cutter = 1'b1;
          end
          if (!HW_SELF_OK) begin
            st_nxt.flt.hw = 1'b1;
          end
          st_nxt.phase = prn_err_pkg::PH_RUN;
        end
      end
      prn_err_pkg::PH_RUN: begin
        if (CUT_DONE && !pins_s[prn_err_pkg::PIN_CUTTER_HOME]) begin
          st_nxt.flt.cutter = 1'b1;
        end
        if (MARK_MISS && st_r.mark_en) begin
          st_nxt.flt.mark = 1'b1;
        end
      end
      default: begin
        st_nxt.phase = prn_err_pkg::PH_BOOT;
      end
    endcase

    // near-end routed to the paper-end pin overrides its own pattern
    if (pe_route) begin
      st_nxt.pins = prn_err_pkg::PAT_PAPER_END;
    end else if (st_r.flt.cutter) begin
      st_nxt.pins = prn_err_pkg::PAT_CUTTER;
    end else if (nonrec) begin
      st_nxt.pins = prn_err_pkg::PAT_NONREC;
    end else if (st_r.flt.temp) begin
      st_nxt.pins = prn_err_pkg::PAT_TEMP;
    end else if (st_r.flt.mark) begin
      st_nxt.pins = prn_err_pkg::PAT_MARK;
    // near-end and idle share this pattern
    end else begin
      st_nxt.pins = prn_err_pkg::PAT_IDLE;
    end

    st_nxt.lamp_err   = err_any;
    st_nxt.lamp_pe    = st_r.flt.paper_end;
    // near-end halts only when told to
    st_nxt.motor_stop = st_r.flt.paper_end || err_any || near_halt;
    st_nxt.dtr        = st_r.flt.paper_end || err_any || near_halt;
  end

  // registered flags; reset clears them but loads ctrl with 1, phase with PH_BOOT and pins with the idle pattern
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_r.phase      <= prn_err_pkg::PH_BOOT;
      st_r.boot_cnt   <= prn_err_pkg::BOOT_CNT_RESET;
      st_r.ctrl       <= prn_err_pkg::CTRL_RESET;
      st_r.mark_en    <= 1'b0;
      st_r.flt        <= prn_err_pkg::FAULT_RESET;
      st_r.pins       <= prn_err_pkg::PINS_RESET;
      st_r.lamp_err   <= 1'b0;
      st_r.lamp_pe    <= 1'b0;
      st_r.motor_stop <= 1'b0;
      st_r.dtr        <= 1'b0;
      st_r.rehome     <= 1'b0;
      st_r.wr_pend    <= 1'b0;
      st_r.wr_addr    <= 8'h00;
      st_r.rdata      <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign HREADYOUT       = 1'b1;
  assign HRESP           = 1'b0;
  assign HRDATA          = st_r.rdata;
  assign PAPER_END_OUT   = st_r.pins.pe;
  assign FAULT_OUT_N     = st_r.pins.fault_n;
  assign STATUS_BIT_LOW  = st_r.pins.st_lo;
  assign STATUS_BIT_HIGH = st_r.pins.st_hi;
  assign FAULT_LAMP      = st_r.lamp_err;
  assign PAPER_LAMP      = st_r.lamp_pe;
  assign MOTOR_STOP      = st_r.motor_stop;
  assign DTR             = st_r.dtr;
  assign CUTTER_REHOME   = st_r.rehome;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  a_temp_set: assert property (MEAS_VALID && HEAD_TEMP_C > prn_err_pkg::TEMP_HOT_C |=> st_r.flt.temp)
    else $error("overheat not flagged");
  a_temp_clear: assert property (MEAS_VALID && HEAD_TEMP_C < prn_err_pkg::TEMP_COOL_C |=> !st_r.flt.temp)
    else $error("temperature fault did not clear");
  a_temp_hyst: assert property (!MEAS_VALID |=> $stable(st_r.flt.temp))
    else $error("temperature fault moved without a sample");
  a_near_pattern: assert property (st_r.flt.near_end && !pe_route && !err_any
    |=> PAPER_END_OUT == 1'b0 && FAULT_OUT_N && !STATUS_BIT_LOW && !STATUS_BIT_HIGH)
    else $error("near-end pattern wrong");
  a_near_routed: assert property (st_r.flt.near_end && st_r.ctrl[prn_err_pkg::SENSOR_NEAR_BIT]
    |=> PAPER_END_OUT && FAULT_OUT_N)
    else $error("routed near-end not on paper-end pin");
  a_temp_pattern: assert property (st_r.flt.temp && !pe_route && !st_r.flt.cutter && !nonrec
    |=> !PAPER_END_OUT && !FAULT_OUT_N && STATUS_BIT_LOW && !STATUS_BIT_HIGH)
    else $error("temperature pattern wrong");
  a_lamp_on: assert property (err_any |=> FAULT_LAMP)
    else $error("fault lamp dark during fault");
  a_dtr_level: assert property (err_any || st_r.flt.paper_end |=> DTR)
    else $error("dtr low during fault");
  a_cut_check: assert property (st_r.phase == prn_err_pkg::PH_RUN && CUT_DONE
    && !pins_s[prn_err_pkg::PIN_CUTTER_HOME] |=> st_r.flt.cutter ##1 (!FAULT_OUT_N || PAPER_END_OUT))
    else $error("cutter fault missed");
  a_cut_pattern: assert property (st_r.flt.cutter && !pe_route
    |=> !PAPER_END_OUT && !FAULT_OUT_N && STATUS_BIT_LOW && STATUS_BIT_HIGH)
    else $error("cutter pattern wrong");
  a_cut_hold: assert property (st_r.flt.cutter |=> st_r.flt.cutter)
    else $error("cutter fault cleared before reset");
  a_rehome_pulse: assert property (st_r.phase == prn_err_pkg::PH_BOOT && $rose(st_nxt.rehome)
    |=> CUTTER_REHOME ##1 !CUTTER_REHOME)
    else $error("re-home pulse wrong");
  a_volt_set: assert property (MEAS_VALID && HEAD_SUPPLY_VOLTAGE > prn_err_pkg::VOLT_MAX_DV
    |=> st_r.flt.volt)
    else $error("overvoltage not flagged");
  a_nonrec_pattern: assert property (nonrec && !pe_route && !st_r.flt.cutter
    |=> !PAPER_END_OUT && !FAULT_OUT_N && !STATUS_BIT_LOW && STATUS_BIT_HIGH)
    else $error("non-recoverable pattern wrong");
  a_volt_latch: assert property (st_r.flt.volt |=> st_r.flt.volt [*2])
    else $error("voltage fault not latched");
  a_volt_low: assert property (MEAS_VALID && HEAD_SUPPLY_VOLTAGE < prn_err_pkg::VOLT_MIN_DV
    |=> st_r.flt.volt)
    else $error("undervoltage not flagged");
  a_volt_quiet: assert property (MEAS_VALID && !st_r.flt.volt && HEAD_SUPPLY_VOLTAGE >= prn_err_pkg::VOLT_MIN_DV
    && HEAD_SUPPLY_VOLTAGE <= prn_err_pkg::VOLT_MAX_DV |=> !st_r.flt.volt)
    else $error("voltage fault inside the window");
  a_hw_latch: assert property (st_r.flt.hw |=> st_r.flt.hw)
    else $error("hardware fault cleared");
  a_hw_check: assert property (st_r.phase == prn_err_pkg::PH_REHOME && REHOME_DONE && !HW_SELF_OK
    |=> st_r.flt.hw && st_r.phase == prn_err_pkg::PH_RUN)
    else $error("hardware fault missed");
  a_mark_off: assert property (!st_r.mark_en && !st_r.flt.mark |=> !st_r.flt.mark)
    else $error("mark fault while disabled");
  a_mark_latch: assert property (st_r.flt.mark |=> st_r.flt.mark)
    else $error("mark fault cleared");
  a_mark_pattern: assert property (st_r.flt.mark && !pe_route && !st_r.flt.cutter && !nonrec && !st_r.flt.temp
    |=> !PAPER_END_OUT && !FAULT_OUT_N && !STATUS_BIT_LOW && !STATUS_BIT_HIGH)
    else $error("mark pattern wrong");
  a_paper_pattern: assert property (st_r.flt.paper_end && st_r.ctrl[prn_err_pkg::SENSOR_PAPER_BIT]
    |=> PAPER_END_OUT && FAULT_OUT_N && !STATUS_BIT_LOW && !STATUS_BIT_HIGH && PAPER_LAMP && MOTOR_STOP)
    else $error("paper-end indication wrong");
  a_near_quiet: assert property (st_r.flt.near_end && !near_halt && !err_any && !st_r.flt.paper_end
    |=> !DTR && !MOTOR_STOP)
    else $error("non-halting near-end raised dtr");
  a_near_halt: assert property (near_halt |=> DTR && MOTOR_STOP)
    else $error("halting near-end did not stop");
  a_dtr_quiet: assert property (!err_any && !st_r.flt.paper_end && !near_halt |=> !DTR)
    else $error("dtr high without a fault");
  a_paper_lamp: assert property (st_r.flt.paper_end |=> PAPER_LAMP && MOTOR_STOP)
    else $error("paper lamp dark while paper missing");
  a_lamp_off: assert property (!err_any |=> !FAULT_LAMP)
    else $error("fault lamp lit without a fault");

  c_temp_cycle: cover property (st_r.flt.temp ##[1:50] !st_r.flt.temp);
  c_cutter: cover property ($rose(st_r.flt.cutter));
  c_near_poll: cover property (st_r.flt.near_end && !DTR ##1 FAULT_OUT_N);
  c_mark: cover property ($rose(st_r.flt.mark));

endmodule : printer_error_reporter

// >>> dv/host_poller.sv
// host model that polls the parallel status pins and watches DTR
`timescale 1ns/10ps
module host_poller #(
  parameter int DTR_LIMIT = 8
) (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire prn_err_pkg::port_pins_t pins,
  input  wire logic                    dtr,
  output prn_err_pkg::port_pins_t      seen,
  output logic                         status_req
);
  int dtr_cnt;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seen <= prn_err_pkg::PINS_RESET;
    end else begin
      seen <= pins;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dtr_cnt    <= 0;
      status_req <= 1'b0;
    end else begin
      dtr_cnt    <= dtr ? dtr_cnt + 1 : 0;
      status_req <= dtr && (dtr_cnt >= DTR_LIMIT);
    end
  end
endmodule : host_poller

// >>> dv/test_printer_error_status_reporter.sv
// self-checking bench of the printer fault reporter with a polling host
`timescale 1ns/10ps
module test_printer_error_status_reporter;
  logic                    CLK, RESETN, HSEL, HWRITE, HREADYOUT, HRESP, MEAS_VALID, HW_SELF_OK;
  logic [1:0]              HTRANS;
  logic [2:0]              HSIZE;
  logic [31:0]             HADDR, HWDATA, HRDATA;
  logic [7:0]              HEAD_TEMP_C;
  logic [8:0]              HEAD_SUPPLY_VOLTAGE;
  logic [4:0]              apins;
  logic [2:0]              pulses;
  logic                    PAPER_END_OUT, FAULT_OUT_N, STATUS_BIT_LOW, STATUS_BIT_HIGH;
  logic                    FAULT_LAMP, PAPER_LAMP, MOTOR_STOP, DTR, CUTTER_REHOME, status_req;
  prn_err_pkg::port_pins_t pins, host_seen;
  int                      err_total, check_count;

  localparam logic [2:0] CUT = 3'h1, MARK = 3'h2, REHOME = 3'h4;

  assign pins = {PAPER_END_OUT, FAULT_OUT_N, STATUS_BIT_HIGH, STATUS_BIT_LOW};

  printer_error_reporter DUT (
    .CLK, .RESETN, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA, .HREADY(HREADYOUT),
    .HREADYOUT, .HRDATA, .HRESP, .PAPER_OUT_IN(apins[prn_err_pkg::PIN_PAPER_OUT]),
    .HEAD_OPEN_IN(apins[prn_err_pkg::PIN_HEAD_OPEN]), .NEAR_END_IN(apins[prn_err_pkg::PIN_NEAR_END]),
    .CUTTER_HOME_IN(apins[prn_err_pkg::PIN_CUTTER_HOME]), .MARK_STRAP_IN(apins[prn_err_pkg::PIN_MARK_STRAP]),
    .CUT_DONE(pulses[0]), .MARK_MISS(pulses[1]), .REHOME_DONE(pulses[2]), .HW_SELF_OK, .MEAS_VALID,
    .HEAD_TEMP_C, .HEAD_SUPPLY_VOLTAGE, .PAPER_END_OUT, .FAULT_OUT_N, .STATUS_BIT_LOW, .STATUS_BIT_HIGH,
    .FAULT_LAMP, .PAPER_LAMP, .MOTOR_STOP, .DTR, .CUTTER_REHOME
  );

  host_poller #(.DTR_LIMIT(8)) host (
    .clk(CLK), .rst_n(RESETN), .pins(pins), .dtr(DTR), .seen(host_seen), .status_req(status_req)
  );

  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (HREADYOUT !== 1'b1 && n < 20);
    if (HREADYOUT !== 1'b1) begin
      err_total++;
      wrap_up();
    end
  endtask : wait_ready

  task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wdata, output logic [31:0] rdata);
    @(posedge CLK);
    HSEL   <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= wr;
    HADDR  <= addr;
    wait_ready();
    HSEL   <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= wdata;
    wait_ready();
    rdata = HRDATA;
  endtask : bus

  task automatic rd_chk(input string what, input logic [31:0] addr, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, addr, 32'h0, d);
    check(what, d & mask, exp);
    check("bus response", {31'h0, HRESP}, 32'h0);
  endtask : rd_chk

  task automatic settle();
    repeat (6) @(posedge CLK);
    @(negedge CLK);
  endtask : settle

  task automatic wr_ctrl(input logic [31:0] data);
    logic [31:0] d;
    bus(1'b1, {24'h0, prn_err_pkg::CTRL_OFS}, data, d);
    settle();
  endtask : wr_ctrl

  task automatic pulse(input logic [2:0] p);
    @(posedge CLK);
    pulses <= p;
    @(posedge CLK);
    pulses <= 3'h0;
    settle();
  endtask : pulse

  task automatic set_pin(input int idx, input logic val);
    @(posedge CLK);
    apins[idx] <= val;
    settle();
  endtask : set_pin

  task automatic meas(input logic [7:0] t, input logic [8:0] v);
    @(posedge CLK);
    MEAS_VALID          <= 1'b1;
    HEAD_TEMP_C         <= t;
    HEAD_SUPPLY_VOLTAGE <= v;
    @(posedge CLK);
    MEAS_VALID <= 1'b0;
    settle();
  endtask : meas

  task automatic outs(input logic [5:0] exp);
    check("pins lamp dtr", {26'h0, pins, FAULT_LAMP, DTR}, {26'h0, exp});
  endtask : outs

  task automatic boot(input logic home, input logic ok, input logic strap);
    int n;
    @(posedge CLK);
    RESETN                                  <= 1'b0;
    apins[prn_err_pkg::PIN_CUTTER_HOME]     <= home;
    apins[prn_err_pkg::PIN_MARK_STRAP]      <= strap;
    HW_SELF_OK                              <= ok;
    repeat (16) @(posedge CLK);
    @(negedge CLK);
    outs({prn_err_pkg::PINS_RESET, 2'h0});
    @(posedge CLK);
    RESETN <= 1'b1;
    n = 0;
    do begin
      @(negedge CLK);
      n++;
    end while (CUTTER_REHOME !== 1'b1 && n < 20);
    check("rehome request", CUTTER_REHOME, 1'b1);
    if (CUTTER_REHOME !== 1'b1) begin
      wrap_up();
    end
    pulse(REHOME);
  endtask : boot

  initial begin
    RESETN = 1'b0; HSEL = 1'b0; HTRANS = 2'h0; HWRITE = 1'b0; HSIZE = 3'h2; HADDR = 32'h0; HWDATA = 32'h0;
    apins = 5'h00; pulses = 3'h0; MEAS_VALID = 1'b0; HW_SELF_OK = 1'b1;
    HEAD_TEMP_C = 8'h19; HEAD_SUPPLY_VOLTAGE = 9'h0F0; err_total = 0; check_count = 0;
    boot(1'b1, 1'b1, 1'b1);
    rd_chk("ctrl reset", 32'h0, 32'hFFFFFFFF, 32'h1);
    rd_chk("unmapped read", 32'h8, 32'hFFFFFFFF, 32'h0);
    rd_chk("status after init", 32'h4, 32'hF07F, 32'h9000);
    set_pin(prn_err_pkg::PIN_NEAR_END, 1'b1);
    outs({prn_err_pkg::PAT_IDLE, 2'h0});
    check("host poll", host_seen, prn_err_pkg::PAT_IDLE);
    check("motor free", MOTOR_STOP, 1'b0);
    wr_ctrl(32'h5);
    check("near end halt", {MOTOR_STOP, DTR}, 2'h3);
    wr_ctrl(32'h3);
    outs({prn_err_pkg::PAT_PAPER_END, 2'h0});
    wr_ctrl(32'h1);
    set_pin(prn_err_pkg::PIN_NEAR_END, 1'b0);
    set_pin(prn_err_pkg::PIN_PAPER_OUT, 1'b1);
    outs({prn_err_pkg::PAT_PAPER_END, 2'h1});
    check("paper lamp motor", {PAPER_LAMP, MOTOR_STOP}, 2'h3);
    wr_ctrl(32'h0);
    outs({prn_err_pkg::PAT_IDLE, 2'h1});
    wr_ctrl(32'h1);
    set_pin(prn_err_pkg::PIN_PAPER_OUT, 1'b0);
    set_pin(prn_err_pkg::PIN_HEAD_OPEN, 1'b1);
    outs({prn_err_pkg::PAT_PAPER_END, 2'h1});
    set_pin(prn_err_pkg::PIN_HEAD_OPEN, 1'b0);
    meas(8'h46, 9'h0F0);
    outs({prn_err_pkg::PAT_IDLE, 2'h0});
    meas(8'h47, 9'h0F0);
    outs({prn_err_pkg::PAT_TEMP, 2'h3});
    meas(8'h3C, 9'h0F0);
    outs({prn_err_pkg::PAT_TEMP, 2'h3});
    check("host status request", status_req, 1'b1);
    meas(8'h3B, 9'h0F0);
    outs({prn_err_pkg::PAT_IDLE, 2'h0});
    meas(8'h19, 9'h0D8);
    meas(8'h19, 9'h108);
    outs({prn_err_pkg::PAT_IDLE, 2'h0});
    pulse(MARK);
    outs({prn_err_pkg::PAT_MARK, 2'h3});
    meas(8'h19, 9'h0D7);
    outs({prn_err_pkg::PAT_NONREC, 2'h3});
    meas(8'h19, 9'h0F0);
    pulse(CUT);
    outs({prn_err_pkg::PAT_NONREC, 2'h3});
    set_pin(prn_err_pkg::PIN_CUTTER_HOME, 1'b0);
    pulse(CUT);
    outs({prn_err_pkg::PAT_CUTTER, 2'h3});
    rd_chk("latched flags", 32'h4, 32'h7F, 32'h0D);
    boot(1'b0, 1'b1, 1'b0);
    outs({prn_err_pkg::PAT_CUTTER, 2'h3});
    pulse(MARK);
    meas(8'h19, 9'h109);
    rd_chk("status no strap", 32'h4, 32'hF07F, 32'h800C);
    boot(1'b1, 1'b0, 1'b1);
    outs({prn_err_pkg::PAT_NONREC, 2'h3});
    rd_chk("status hw fault", 32'h4, 32'hF07F, 32'h9002);
    wrap_up();
  end
endmodule : test_printer_error_status_reporter
